/* src/ftx_pkg.sv */
package ftx_pkg;

    typedef enum logic [2:0] {
        FTX_TM_OFF      = 3'b000,
        FTX_TM_ACTIVE   = 3'b001,
        FTX_TM_IDLE     = 3'b010,
        FTX_TM_MASTER   = 3'b011,
        FTX_TM_QUIET    = 3'b100,
        FTX_TM_RESERVED = 3'b101,
        FTX_TM_HALT     = 3'b110
    } ftx_tx_mode_t;

    typedef enum logic [1:0] {
        FTX_IC_NONE     = 2'b00,
        FTX_IC_ONE_SHOT = 2'b01,
        FTX_IC_PERIODIC = 2'b10,
        FTX_IC_CONT     = 2'b11
    } ftx_inj_mode_t;

    typedef enum logic [1:0] {
        FTX_SRC_A_REQ   = 2'b00,
        FTX_SRC_B_REQ   = 2'b01,
        FTX_SRC_RX      = 2'b10,
        FTX_SRC_INVALID = 2'b11
    } ftx_src_t;

    typedef struct packed {
        logic       parity;
        logic       ctrl;
        logic [3:0] hi;
        logic [3:0] lo;
    } ftx_byte_t;

    typedef struct packed {
        ftx_src_t sel_tx;
        ftx_src_t sel_b_ind;
        ftx_src_t sel_a_ind;
    } ftx_cfg_t;

endpackage

/* src/ftx_regs.svh */
`ifndef FTX_REGS_SVH
`define FTX_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FTX_OFF_MODE      8'h00
`define FTX_OFF_CONFIG    8'h04
`define FTX_OFF_TX_STATE  8'h08
`define FTX_OFF_INJ_CTRL  8'h0c
`define FTX_OFF_INJ_THR   8'h10
`define FTX_OFF_INJ_SYM_A 8'h14
`define FTX_OFF_INJ_SYM_B 8'h18
`define FTX_OFF_STATUS    8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FTX_MODE_NRZ_BIT  6
`define FTX_TM_LSB        0
`define FTX_IC_LSB        0
`define FTX_ST_DONE_BIT   0
`define FTX_ST_ARMED_BIT  1
`define FTX_ST_TXEN_BIT   2
`define FTX_ST_CNT_LSB    8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FTX_RST_MODE      8'h00
`define FTX_RST_CONFIG    6'h00
`define FTX_RST_TX_STATE  3'h0
`define FTX_RST_INJ_CTRL  2'h0
`define FTX_RST_INJ_THR   8'h00
`define FTX_RST_INJ_SYM   5'h00

// ----------------------------------------------------------------
// symbols and timing
// ----------------------------------------------------------------
`define FTX_SYM_QUIET     5'h00
`define FTX_SYM_IDLE      5'h1f
`define FTX_SYM_HALT      5'h04
`define FTX_SYM_J         5'h18
`define FTX_SYM_K         5'h11
`define FTX_SYM_T         5'h0d
`define FTX_SYM_R         5'h07
`define FTX_SYM_S         5'h19
`define FTX_UNKNOWN_LINE  10'h13a
`define FTX_JK_BYTE       8'hdd
`define FTX_BITS_PER_BYTE 4'ha
`define FTX_LAST_BIT      4'h9

`endif

/* src/ftx_top.sv */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ftx_regs.svh"

// Function
// R1 - transmit mode comes from tx_state_reg bits 0 to 2
// R2 - forced modes replace the normal data path output with generated pairs
// R3 - active mode sends the byte from the switch transmit path
// R4 - off mode sends Quiet pairs and drops the PMD transmit enable
// R5 - idle mode sends only Idle pairs
// R6 - master mode sends Halt-Quiet pairs continuously
// R7 - quiet mode and reserved code send Quiet pairs
// R8 - halt mode sends Halt pairs continuously
// R9 - injected pairs win over generated pairs and over data
// R10 - two-bit injection field chooses none, one shot, periodic, continuous
// R11 - no injection leaves the stream untouched
// R12 - one shot replaces byte n after a JK, once
// R13 - one shot with threshold zero replaces the JK itself
// R14 - periodic replaces every nth pair, zero replaces every pair; this implementation replaces every (n+1)th pair
// R15 - continuous replaces every pair, like periodic with zero
// R16 - threshold holds 0 to 255
// R17 - pair loads once per byte period, then shifts out bit by bit
// R18 - mode_reg bit 6 zero gives NRZI, one gives plain NRZ
// R19 - switch sources: A request, B request, receive path, fixed pattern
// R20 - fixed pattern bus always carries 1 0011 1010
// R21 - three independent selectors drive A indicate, B indicate, transmit
// R22 - single-port variant uses only B request and A indicate
// R23 - request words carry odd parity, control flag, two symbols
// R24 - each transmit mode has its own fixed three-bit code
// R25 - per-output source selects apply only at byte boundaries
module ftx_top import ftx_pkg::*; #(
    parameter bit SINGLE_PORT = 1'b0
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire ftx_byte_t   a_req_i,
    input  wire ftx_byte_t   b_req_i,
    input  wire ftx_byte_t   rx_data_i,
    output ftx_byte_t        a_ind_o,
    output ftx_byte_t        b_ind_o,
    output logic             byte_strobe_o,
    output logic             tx_serial_o,
    output logic             pmd_tx_enable_o
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == `FTX_OFF_MODE) || (a == `FTX_OFF_CONFIG) ||
                  (a == `FTX_OFF_TX_STATE) || (a == `FTX_OFF_INJ_CTRL) ||
                  (a == `FTX_OFF_INJ_THR) || (a == `FTX_OFF_INJ_SYM_A) ||
                  (a == `FTX_OFF_INJ_SYM_B) || (a == `FTX_OFF_STATUS);
    endfunction

    function automatic logic [4:0] enc_data(input logic [3:0] n);
        logic [4:0] c;
        c = 5'h1e;
        unique case (n)
            4'h0: c = 5'h1e;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0a;
            4'h5: c = 5'h0b;
            4'h6: c = 5'h0e;
            4'h7: c = 5'h0f;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'ha: c = 5'h16;
            4'hb: c = 5'h17;
            4'hc: c = 5'h1a;
            4'hd: c = 5'h1b;
            4'he: c = 5'h1c;
            4'hf: c = 5'h1d;
        endcase
        return c;
    endfunction

    // control nibbles; unlisted ones fall back to Idle so nothing illegal leaves
    function automatic logic [4:0] enc_ctrl(input logic [3:0] n, input logic first);
        logic [4:0] c;
        c = `FTX_SYM_IDLE;
        if (n == 4'hd) begin
            c = first ? `FTX_SYM_J : `FTX_SYM_K;
        end else if (n == 4'h4 || n == 4'h5) begin
            c = `FTX_SYM_T;
        end else if (n == 4'h6) begin
            c = `FTX_SYM_R;
        end else if (n == 4'h7) begin
            c = `FTX_SYM_S;
        end
        return c;
    endfunction

    function automatic logic [9:0] enc_pair(input ftx_byte_t b);
        logic [9:0] p;
        p = '0;
        if (b.ctrl) begin
            p = {enc_ctrl(b.hi, 1'b1), enc_ctrl(b.lo, 1'b0)};
        end else begin
            p = {enc_data(b.hi), enc_data(b.lo)};
        end
        return p;
    endfunction

    function automatic ftx_byte_t pick(input ftx_src_t s, input ftx_byte_t a,
                                       input ftx_byte_t b, input ftx_byte_t r);
        ftx_byte_t o;
        o = ftx_byte_t'(`FTX_UNKNOWN_LINE);
        unique case (s)
            FTX_SRC_A_REQ:   o = a;
            FTX_SRC_B_REQ:   o = b;
            FTX_SRC_RX:      o = r;
            FTX_SRC_INVALID: o = ftx_byte_t'(`FTX_UNKNOWN_LINE);
        endcase
        return o;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] mode_q;
    ftx_cfg_t cfg_q;
    ftx_cfg_t cfg_act_q;
    ftx_tx_mode_t tx_mode_q;
    ftx_inj_mode_t inj_mode_q;
    logic [7:0] inj_thr_q;
    logic [4:0] inj_sym_a_q;
    logic [4:0] inj_sym_b_q;
    logic [31:0] rdata_q;
    logic done_q;
    logic armed_q;
    logic track_q;
    logic [7:0] cnt_q;
    logic [3:0] bit_cnt_q;
    logic [9:0] pair_q;
    logic [9:0] shift_q;
    logic line_q;
    logic txen_q;
    ftx_byte_t a_ind_q;
    ftx_byte_t b_ind_q;

    logic setup;
    logic wr_en;
    logic w1c_done;
    logic byte_load;
    ftx_byte_t a_src;
    ftx_byte_t tx_byte;
    logic jk_now;
    logic [7:0] pos;
    logic inject;
    logic [9:0] gen_pair;
    logic gen_force;
    logic [9:0] pair_d;
    logic [7:0] cnt_inc;

    // ----------------------------------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------------------------------
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pwrite_i && addr_ok(paddr_i);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok(paddr_i);
    assign prdata_o = rdata_q;
    assign w1c_done = wr_en && (paddr_i == `FTX_OFF_STATUS) && pwdata_i[`FTX_ST_DONE_BIT];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite_i) begin
            unique case (paddr_i)
                `FTX_OFF_MODE:      rdata_q <= {24'h00_0000, mode_q};
                `FTX_OFF_CONFIG:    rdata_q <= {26'h000_0000, cfg_q};
                `FTX_OFF_TX_STATE:  rdata_q <= {29'h0000_0000, tx_mode_q};
                `FTX_OFF_INJ_CTRL:  rdata_q <= {30'h0000_0000, inj_mode_q};
                `FTX_OFF_INJ_THR:   rdata_q <= {24'h00_0000, inj_thr_q};
                `FTX_OFF_INJ_SYM_A: rdata_q <= {27'h000_0000, inj_sym_a_q};
                `FTX_OFF_INJ_SYM_B: rdata_q <= {27'h000_0000, inj_sym_b_q};
                `FTX_OFF_STATUS:    rdata_q <= {16'h0000, cnt_q, 5'h00, txen_q, armed_q, done_q};
                default:            rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q <= `FTX_RST_MODE;
            cfg_q <= ftx_cfg_t'(`FTX_RST_CONFIG);
            tx_mode_q <= ftx_tx_mode_t'(`FTX_RST_TX_STATE);
            inj_mode_q <= ftx_inj_mode_t'(`FTX_RST_INJ_CTRL);
            inj_thr_q <= `FTX_RST_INJ_THR;
            inj_sym_a_q <= `FTX_RST_INJ_SYM;
            inj_sym_b_q <= `FTX_RST_INJ_SYM;
        end else if (wr_en) begin
            unique case (paddr_i)
                `FTX_OFF_MODE:      mode_q <= pwdata_i[7:0];
                `FTX_OFF_CONFIG:    cfg_q <= ftx_cfg_t'(pwdata_i[5:0]);
                `FTX_OFF_TX_STATE:  tx_mode_q <= ftx_tx_mode_t'(pwdata_i[`FTX_TM_LSB +: 3]); // R1 R24
                `FTX_OFF_INJ_CTRL:  inj_mode_q <= ftx_inj_mode_t'(pwdata_i[`FTX_IC_LSB +: 2]); // R10
                `FTX_OFF_INJ_THR:   inj_thr_q <= pwdata_i[7:0]; // R16
                `FTX_OFF_INJ_SYM_A: inj_sym_a_q <= pwdata_i[4:0];
                `FTX_OFF_INJ_SYM_B: inj_sym_b_q <= pwdata_i[4:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // byte timing: one pair per ten bit periods
    // ----------------------------------------------------------------
    assign byte_load = (bit_cnt_q == `FTX_LAST_BIT);
    assign byte_strobe_o = byte_load;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cnt_q <= 4'h0;
        end else if (byte_load) begin
            bit_cnt_q <= 4'h0; // R17
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // configuration switch
    // ----------------------------------------------------------------
    // the unused request path is ignored so a floating pin cannot leak in
    assign a_src = SINGLE_PORT ? ftx_byte_t'(`FTX_UNKNOWN_LINE) : a_req_i; // R22
    // selects come from the copy taken at the last load so a change lands on a byte boundary
    assign tx_byte = pick(cfg_act_q.sel_tx, a_src, b_req_i, rx_data_i); // R19 R21
    assign a_ind_o = a_ind_q;
    assign b_ind_o = b_ind_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_act_q <= ftx_cfg_t'(`FTX_RST_CONFIG);
            a_ind_q <= ftx_byte_t'(`FTX_UNKNOWN_LINE);
            b_ind_q <= ftx_byte_t'(`FTX_UNKNOWN_LINE);
        end else if (byte_load) begin
            cfg_act_q <= cfg_q; // R25
            a_ind_q <= pick(cfg_q.sel_a_ind, a_src, b_req_i, rx_data_i); // R20 R21
            b_ind_q <= SINGLE_PORT ? ftx_byte_t'(`FTX_UNKNOWN_LINE) :
                       pick(cfg_q.sel_b_ind, a_src, b_req_i, rx_data_i); // R22
        end
    end

    // ----------------------------------------------------------------
    // line state generator
    // ----------------------------------------------------------------
    always_comb begin
        gen_force = 1'b1;
        gen_pair = {`FTX_SYM_QUIET, `FTX_SYM_QUIET};
        unique case (tx_mode_q)
            FTX_TM_ACTIVE: begin
                gen_force = 1'b0; // R3
            end
            FTX_TM_OFF:      gen_pair = {`FTX_SYM_QUIET, `FTX_SYM_QUIET}; // R4
            FTX_TM_IDLE:     gen_pair = {`FTX_SYM_IDLE, `FTX_SYM_IDLE}; // R5
            FTX_TM_MASTER:   gen_pair = {`FTX_SYM_HALT, `FTX_SYM_QUIET}; // R6
            FTX_TM_QUIET:    gen_pair = {`FTX_SYM_QUIET, `FTX_SYM_QUIET}; // R7
            FTX_TM_RESERVED: gen_pair = {`FTX_SYM_QUIET, `FTX_SYM_QUIET}; // R7
            FTX_TM_HALT:     gen_pair = {`FTX_SYM_HALT, `FTX_SYM_HALT}; // R8
            default:         gen_pair = {`FTX_SYM_QUIET, `FTX_SYM_QUIET}; // R7
        endcase
    end

    // ----------------------------------------------------------------
    // injection control
    // ----------------------------------------------------------------
    assign jk_now = tx_byte.ctrl && ({tx_byte.hi, tx_byte.lo} == `FTX_JK_BYTE);
    assign cnt_inc = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
    assign pos = jk_now ? 8'h00 : cnt_inc;

    always_comb begin
        inject = 1'b0;
        unique case (inj_mode_q)
            FTX_IC_NONE:     inject = 1'b0; // R11
            FTX_IC_ONE_SHOT: inject = armed_q && (jk_now || track_q) && (pos == inj_thr_q); // R12 R13
            FTX_IC_PERIODIC: inject = (cnt_q == inj_thr_q); // R14
            FTX_IC_CONT:     inject = 1'b1; // R15
        endcase
    end

    always_comb begin
        pair_d = enc_pair(tx_byte);
        if (inject) begin
            pair_d = {inj_sym_a_q, inj_sym_b_q}; // R9
        end else if (gen_force) begin
            pair_d = gen_pair; // R2
        end
    end

    // one shot re-arms only on a write that selects it; done is sticky, set wins
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed_q <= 1'b0;
            track_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (wr_en && paddr_i == `FTX_OFF_INJ_CTRL) begin
                armed_q <= (pwdata_i[`FTX_IC_LSB +: 2] == FTX_IC_ONE_SHOT);
                track_q <= 1'b0;
            end else if (byte_load && inj_mode_q == FTX_IC_ONE_SHOT) begin
                if (inject) begin
                    armed_q <= 1'b0; // R12
                    track_q <= 1'b0;
                end else if (jk_now && armed_q) begin
                    track_q <= 1'b1;
                end
            end
            if (byte_load && inject && inj_mode_q == FTX_IC_ONE_SHOT) begin
                done_q <= 1'b1;
            end else if (w1c_done) begin
                done_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= 8'h00;
        end else if (wr_en && paddr_i == `FTX_OFF_INJ_CTRL) begin
            cnt_q <= 8'h00;
        end else if (byte_load) begin
            if (inj_mode_q == FTX_IC_PERIODIC) begin
                cnt_q <= inject ? 8'h00 : cnt_inc; // R14
            end else if (inj_mode_q == FTX_IC_ONE_SHOT) begin
                cnt_q <= pos;
            end
        end
    end

    // ----------------------------------------------------------------
    // serializer and line coder
    // ----------------------------------------------------------------
    assign tx_serial_o = line_q;
    assign pmd_tx_enable_o = txen_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pair_q <= {`FTX_SYM_QUIET, `FTX_SYM_QUIET};
            shift_q <= {`FTX_SYM_QUIET, `FTX_SYM_QUIET};
            txen_q <= 1'b0;
        end else if (byte_load) begin
            pair_q <= pair_d;
            shift_q <= pair_d; // R17
            txen_q <= (tx_mode_q != FTX_TM_OFF); // R4
        end else begin
            shift_q <= {shift_q[8:0], 1'b0}; // R17
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_q <= 1'b0;
        end else if (mode_q[`FTX_MODE_NRZ_BIT]) begin
            line_q <= shift_q[9]; // R18
        end else begin
            line_q <= line_q ^ shift_q[9]; // R18
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence load_s;
        byte_load;
    endsequence

    sequence next_load_s;
        !byte_load [*8] ##1 !byte_load ##1 byte_load;
    endsequence

    load_period_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
        load_s |=> next_load_s) else $error("byte load period is not ten clocks");
    load_shift_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
        load_s |=> (shift_q == pair_q) ##1 (shift_q == {$past(shift_q[8:0]), 1'b0}))
        else $error("serializer did not load or shift");
    mode_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R1
        wr_en && paddr_i == `FTX_OFF_TX_STATE |=> tx_mode_q == $past(pwdata_i[2:0]))
        else $error("transmit mode not taken from bits 2 to 0");
    off_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R4
        load_s and tx_mode_q == FTX_TM_OFF && !inject |=> !pmd_tx_enable_o &&
        pair_q == {`FTX_SYM_QUIET, `FTX_SYM_QUIET}) else $error("off mode pair or enable wrong");
    idle_pair_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
        load_s and tx_mode_q == FTX_TM_IDLE && inj_mode_q == FTX_IC_NONE |=>
        pair_q == {`FTX_SYM_IDLE, `FTX_SYM_IDLE}) else $error("idle mode pair wrong");
    master_pair_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R6
        load_s and tx_mode_q == FTX_TM_MASTER && inj_mode_q == FTX_IC_NONE |=>
        pair_q == {`FTX_SYM_HALT, `FTX_SYM_QUIET}) else $error("master mode pair wrong");
    halt_pair_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
        load_s and tx_mode_q == FTX_TM_HALT && inj_mode_q == FTX_IC_NONE |=>
        pair_q == {`FTX_SYM_HALT, `FTX_SYM_HALT}) else $error("halt mode pair wrong");
    active_pass_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R3
        load_s and tx_mode_q == FTX_TM_ACTIVE && inj_mode_q == FTX_IC_NONE |=>
        pair_q == $past(enc_pair(tx_byte))) else $error("active mode altered data");
    cont_inject_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R9
        load_s and inj_mode_q == FTX_IC_CONT |=> pair_q == {inj_sym_a_q, inj_sym_b_q})
        else $error("continuous injection lost priority");
    jk_replace_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
        load_s and inj_mode_q == FTX_IC_ONE_SHOT && armed_q && jk_now && inj_thr_q == 8'h00
        |=> !armed_q && pair_q == {inj_sym_a_q, inj_sym_b_q}) else $error("JK not replaced");
    nrzi_line_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R18
        !mode_q[`FTX_MODE_NRZ_BIT] |=> line_q == ($past(line_q) ^ $past(shift_q[9])))
        else $error("NRZI toggle wrong");
    fixed_bus_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R20
        load_s and cfg_q.sel_a_ind == FTX_SRC_INVALID |=> a_ind_o == `FTX_UNKNOWN_LINE)
        else $error("fixed pattern bus wrong");

endmodule

/* verification/ftx_far_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side: request source and serial line sampler
// ----------------------------------------------------------------
module ftx_far_model import ftx_pkg::*; (
    input  wire logic  clk_i,
    input  wire logic  resetn_i,
    input  wire logic  byte_strobe_i,
    input  wire logic  tx_serial_i,
    output ftx_byte_t  a_req_o,
    output ftx_byte_t  b_req_o,
    output ftx_byte_t  rx_o,
    output logic [9:0] word_o,
    output int         nwords_o
);
    logic [9:0] sh_q;
    int cnt_q;
    logic strobe_q;
    // odd parity: total ones in the word, parity bit included, is odd
    assign a_req_o = '{1'b1, 1'b0, 4'h3, 4'h5};
    assign b_req_o = '{1'b1, 1'b0, 4'h6, 4'h9};
    // receive path carries a steady starting delimiter for the one shot test
    assign rx_o = '{1'b0, 1'b1, 4'hd, 4'hd};
    // first bit of a pair is on the line two edges after its load strobe
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strobe_q <= 1'b0;
            cnt_q <= 0;
            sh_q <= 10'h000;
            nwords_o <= 0;
            word_o <= 10'h000;
        end else begin
            strobe_q <= byte_strobe_i;
            if (cnt_q != 0) begin
                sh_q <= {sh_q[8:0], tx_serial_i};
            end
            if (cnt_q == 10) begin
                word_o <= {sh_q[8:0], tx_serial_i};
                nwords_o <= nwords_o + 1;
            end
            cnt_q <= strobe_q ? 1 : ((cnt_q == 10 || cnt_q == 0) ? 0 : cnt_q + 1);
        end
    end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "ftx_regs.svh"
module tb_top import ftx_pkg::*; ;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, strobe, txs, txen;
    ftx_byte_t a_req, b_req, rx, a_ind, b_ind;
    logic [9:0] word;
    int nwords;
    int failures = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic err;
    logic [9:0] w;
    logic [2:0] modes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [9:0] pats [6] = '{10'h000, 10'h3ff, 10'h080, 10'h000, 10'h000, 10'h084};

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    ftx_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .a_req_i(a_req), .b_req_i(b_req),
        .rx_data_i(rx), .a_ind_o(a_ind), .b_ind_o(b_ind), .byte_strobe_o(strobe),
        .tx_serial_o(txs), .pmd_tx_enable_o(txen));
    ftx_far_model far (.clk_i(clk_i), .resetn_i(resetn_i), .byte_strobe_i(strobe),
        .tx_serial_i(txs), .a_req_o(a_req), .b_req_o(b_req), .rx_o(rx),
        .word_o(word), .nwords_o(nwords));

    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask

    // apb transfer; waits on pready rather than assuming zero wait states
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            failures++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // three words flush pairs loaded before the last write
    task line_word();
        int i;
        int n0;
        n0 = nwords;
        for (i = 0; i < 100 && nwords < n0 + 3; i++) @(negedge clk_i);
        if (i == 100) begin
            failures++;
            end_sim();
        end
        w = word;
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        chk("ind_a_rst", a_ind, 10'h13a);
        resetn_i <= 1'b1;
        apb(0, `FTX_OFF_CONFIG, 0);
        chk("cfg_rst", rd, 32'h0);
        apb(0, `FTX_OFF_TX_STATE, 0);
        chk("tm_rst", rd, 32'h0);
        apb(1, `FTX_OFF_TX_STATE, 32'hff);
        apb(0, `FTX_OFF_TX_STATE, 0);
        chk("tm_width", rd, 32'h7);
        apb(1, `FTX_OFF_INJ_THR, 32'h1ff);
        apb(0, `FTX_OFF_INJ_THR, 0);
        chk("thr_max", rd, 32'hff);
        apb(0, 8'h20, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        // switch: indicate outputs from B request, fixed pattern, A request, receive path
        apb(1, `FTX_OFF_CONFIG, 32'h2d);
        line_word();
        chk("a_from_b", a_ind, b_req);
        chk("b_fixed", b_ind, 10'h13a);
        apb(1, `FTX_OFF_CONFIG, 32'h08);
        line_word();
        chk("a_from_a", a_ind, a_req);
        chk("b_from_rx", b_ind, rx);
        apb(1, `FTX_OFF_MODE, 32'h40);
        for (int k = 0; k < 6; k++) begin
            apb(1, `FTX_OFF_TX_STATE, modes[k]);
            line_word();
            chk("forced_pair", w, pats[k]);
            chk("pmd_en", txen, modes[k] != 3'h0);
        end
        apb(1, `FTX_OFF_INJ_THR, 0);
        apb(1, `FTX_OFF_INJ_SYM_A, 32'h15);
        apb(1, `FTX_OFF_INJ_SYM_B, 32'h0a);
        apb(1, `FTX_OFF_INJ_CTRL, 32'h3);
        line_word();
        chk("inj_cont", w, 10'h2aa);
        apb(1, `FTX_OFF_INJ_CTRL, 32'h2);
        line_word();
        chk("inj_per0", w, 10'h2aa);
        apb(1, `FTX_OFF_INJ_CTRL, 32'h0);
        line_word();
        chk("inj_none", w, 10'h084);
        // nrzi: all-ones idle pairs toggle the line every bit
        apb(1, `FTX_OFF_MODE, 32'h0);
        apb(1, `FTX_OFF_TX_STATE, 32'h2);
        line_word();
        chk("nrzi", w[8:0] ^ w[9:1], 9'h1ff);
        apb(1, `FTX_OFF_MODE, 32'h40);
        apb(1, `FTX_OFF_TX_STATE, 32'h1);
        line_word();
        chk("active_en", txen, 1'b1);
        chk("active_data", w, 10'h2ab);
        // one shot on the receive path, which carries starting delimiters
        apb(1, `FTX_OFF_CONFIG, 32'h28);
        apb(1, `FTX_OFF_INJ_CTRL, 32'h1);
        line_word();
        apb(0, `FTX_OFF_STATUS, 0);
        chk("one_shot_done", rd, 32'h5);
        apb(1, `FTX_OFF_STATUS, 32'h1);
        apb(0, `FTX_OFF_STATUS, 0);
        chk("done_clear", rd, 32'h4);
        line_word();
        chk("one_shot_once", w, 10'h311);
        end_sim();
    end
endmodule
